// File: tb/refclk_load.sv
// Far-side load that times the reference clock pin
module refclk_load (
  input wire logic pin,
  input wire logic oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int last_t = 0;
  int period = 0;
  // Only edges seen while the pin is driven count as a period
  always @(posedge pin) begin
    if (oe) period = int'($time) - last_t;
    last_t = int'($time);
  end
endmodule : refclk_load

// File: tb/tb_reference_clock_output_divider.sv
// Self-checking bench for the reference clock output divider
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_reference_clock_output_divider;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, prdata, q;
  logic        pready, pslverr, err, osc = 0, sys = 0, sleep = 0, dflt_ok = 0, pin, oe;
  int          err_total = 0, comparisons = 0, cycles = 0;
  always #5 pclk = ~pclk;
  // Base periods are whole multiples of pclk so measured periods are exact
  always #40 sys = ~sys;
  always #80 osc = ~osc;
  reference_clock_output_divider dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .primary_osc_clk(osc),
    .system_clk(sys), .sleep_mode(sleep), .primary_osc_default_ok(dflt_ok),
    .refclk_out_pin(pin), .refclk_out_pin_oe(oe));
  refclk_load load (.pin(pin), .oe(oe));
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic run(input logic [7:0] ctrl, input int ns);
    apb(1'b1, 12'h000, ctrl);
    repeat (ns / 10 + 20) @(posedge pclk);
  endtask : run
  task automatic t_regs();
    apb(1'b0, 12'h000, 8'h00);
    `CHK(q, 32'h00000000)
    apb(1'b1, 12'h000, 8'hFF);
    apb(1'b0, 12'h000, 8'h00);
    `CHK(q, 32'h000000BF)
    apb(1'b1, 12'h004, 8'h12);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h000, 8'h00);
    `CHK(q, 32'h000000BF)
  endtask : t_regs
  task automatic t_div();
    for (int n = 0; n < 5; n++) begin
      run(8'h80 | 8'(n), (80 << n) * 3);
      `CHK(load.period, 80 << n)
      `CHK(oe, 1'b1)
    end
  endtask : t_div
  task automatic t_src();
    run(8'h92, 2000);
    `CHK(load.period, 640)
    run(8'h81, 500);
    `CHK(load.period, 160)
  endtask : t_src
  task automatic t_off();
    run(8'h02, 300);
    `CHK({oe, pin}, 2'b00)
  endtask : t_off
  task automatic t_sleep();
    @(posedge pclk);
    sleep <= 1'b1;
    run(8'h80, 300);
    `CHK(oe, 1'b0)
    run(8'hA0, 300);
    `CHK(load.period, 80)
    run(8'hB0, 500);
    `CHK(oe, 1'b0)
    // configuration marks a crystal or external clock as default
    dflt_ok <= 1'b1;
    repeat (60) @(posedge pclk);
    `CHK(load.period, 160)
  endtask : t_sleep
  task automatic print_verdict();
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_div();
    t_src();
    t_off();
    t_sleep();
    print_verdict();
  end
endmodule : tb_reference_clock_output_divider

// File: verilog/refclk_pkg.sv
// Register map, field layout and sizes for the reference clock output divider
package refclk_pkg;
  localparam int unsigned APB_AW        = 12;
  localparam int unsigned APB_DW        = 32;
  localparam int unsigned CTRL_W        = 8;
  localparam int unsigned DIV_W         = 4;
  localparam int unsigned CNT_W         = 15;
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_WMASK    = 8'hBF;
  localparam int unsigned BIT_OUT_EN    = 7;
  localparam int unsigned BIT_RSVD      = 6;
  localparam int unsigned BIT_RUN_SLEEP = 5;
  localparam int unsigned BIT_SRC_SEL   = 4;
  localparam int unsigned DIV_LSB       = 0;
  localparam logic [3:0]  DIV_BYPASS    = 4'h0;
  localparam logic [14:0] CNT_ONE       = 15'h0001;
  localparam logic [14:0] CNT_ZERO      = 15'h0000;
  localparam logic [23:0] RDATA_PAD     = 24'h000000;
endpackage : refclk_pkg

// File: verilog/reference_clock_output_divider.sv
// Reference clock output divider with APB control register
// Functional notes
// - Output enable set drives divided clock on the pin; clear disables it.
// - Run-in-sleep set keeps clock running in sleep, for the primary source only with primary_osc_default_ok; clear stops it there.
// - Source select 1 picks primary oscillator, 0 picks the system clock.
// - Base clock divided by two to the power of the 4-bit divisor.
//
// Control register, one byte at offset 0x000:
//   bit 7    output enable
//   bit 6    unimplemented, reads zero
//   bit 5    keep running in sleep
//   bit 4    base source, 1 primary oscillator, 0 system clock
//   bits 3:0 divisor exponent, ratio is two to this power
// Base clocks are sampled by pclk, so each must stay below a quarter of it.
// A write that changes the source or divisor restarts the divider cleanly.
//
// Chosen here: the APB slave port and the register offsets.
module reference_clock_output_divider (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        primary_osc_clk,
  input  wire logic        system_clk,
  input  wire logic        sleep_mode,
  input  wire logic        primary_osc_default_ok,
  output logic             refclk_out_pin,
  output logic             refclk_out_pin_oe
);

  typedef struct packed {
    logic                               prim_s1;
    logic                               prim_s2;
    logic                               sys_s1;
    logic                               sys_s2;
    logic                               base_prev;
    logic [refclk_pkg::CNT_W-1:0]       cnt;
    logic                               out;
    logic                               oe;
    logic [refclk_pkg::CTRL_W-1:0]      ctrl;
    logic [refclk_pkg::DIV_W:0]         cfg_prev;
    logic [refclk_pkg::APB_DW-1:0]      prdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  // Address decode shared by read and write paths
  function automatic logic ctrl_hit(input logic [11:0] addr);
    ctrl_hit = (addr == refclk_pkg::CTRL_OFFSET);
  endfunction : ctrl_hit

  logic                          out_en;
  logic                          run_sleep;
  logic                          src_sel;
  logic [refclk_pkg::DIV_W-1:0]  divisor;
  logic                          base_lvl;
  logic                          base_rise;
  logic                          active;
  logic                          cfg_change;
  logic [refclk_pkg::CNT_W-1:0]  half_m1;
  logic                          wr_go;

  assign out_en    = st_ff.ctrl[refclk_pkg::BIT_OUT_EN];
  assign run_sleep = st_ff.ctrl[refclk_pkg::BIT_RUN_SLEEP];
  assign src_sel   = st_ff.ctrl[refclk_pkg::BIT_SRC_SEL];
  assign divisor   = st_ff.ctrl[refclk_pkg::DIV_LSB +: refclk_pkg::DIV_W];

  // Both sources pass two flops, so edges show up about three pclk late
  // source select
  assign base_lvl  = src_sel ? st_ff.prim_s2 : st_ff.sys_s2;
  assign base_rise = base_lvl & ~st_ff.base_prev;

  // sleep gate; primary source only survives sleep when configured for it
  assign active = out_en & (~sleep_mode | (run_sleep & (~src_sel | primary_osc_default_ok)));

  assign cfg_change = ({src_sel, divisor} != st_ff.cfg_prev);

  // half period in base edges is 2^(div-1); toggling doubles it to 2^div
  assign half_m1 = (divisor == refclk_pkg::DIV_BYPASS) ? refclk_pkg::CNT_ZERO :
                   (refclk_pkg::CNT_W'(refclk_pkg::CNT_ONE << (divisor - 4'h1))
                    - refclk_pkg::CNT_ONE);

  assign wr_go = psel & penable & pwrite & ctrl_hit(paddr) & pstrb[0];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.prim_s1   = primary_osc_clk;
    nxt_st.prim_s2   = st_ff.prim_s1;
    nxt_st.sys_s1    = system_clk;
    nxt_st.sys_s2    = st_ff.sys_s1;
    nxt_st.base_prev = base_lvl;
    nxt_st.cfg_prev  = {src_sel, divisor};
    nxt_st.oe        = active;
    // Restart on any config change so a new ratio never yields a runt period
    if (!active || cfg_change) begin
      nxt_st.cnt = refclk_pkg::CNT_ZERO;
      nxt_st.out = 1'b0;
    end else if (divisor == refclk_pkg::DIV_BYPASS) begin
      // undivided path follows the synchronised base clock
      nxt_st.cnt = refclk_pkg::CNT_ZERO;
      nxt_st.out = base_lvl;
    end else if (base_rise) begin
      if (st_ff.cnt == half_m1) begin
        nxt_st.cnt = refclk_pkg::CNT_ZERO;
        nxt_st.out = ~st_ff.out;
      end else begin
        nxt_st.cnt = st_ff.cnt + refclk_pkg::CNT_ONE;
      end
    end
    // write keeps the unimplemented bit at zero
    if (wr_go) begin
      nxt_st.ctrl = pwdata[refclk_pkg::CTRL_W-1:0] & refclk_pkg::CTRL_WMASK;
    end
    // Read data is loaded in the setup phase so the access phase needs no wait
    if (psel && !penable && !pwrite) begin
      if (ctrl_hit(paddr)) begin
        nxt_st.prdata = {refclk_pkg::RDATA_PAD, st_ff.ctrl};
      end else begin
        nxt_st.prdata = {refclk_pkg::RDATA_PAD, refclk_pkg::CTRL_RESET};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata            = st_ff.prdata;
  assign pready            = 1'b1;
  assign pslverr           = psel & penable & ~ctrl_hit(paddr);
  assign refclk_out_pin    = st_ff.out;
  assign refclk_out_pin_oe = st_ff.oe;

  // Checks
  sequence s_half_done;
    active && !cfg_change && base_rise && divisor != refclk_pkg::DIV_BYPASS
      && st_ff.cnt == half_m1;
  endsequence

  sequence s_apb_write;
    psel && !penable && pwrite ##1 wr_go;
  endsequence

  sequence s_apb_read;
    psel && !penable && !pwrite;
  endsequence

  sequence s_bypass_on;
    active && !cfg_change && divisor == refclk_pkg::DIV_BYPASS;
  endsequence

  sequence s_divided_on;
    active && !cfg_change && divisor != refclk_pkg::DIV_BYPASS;
  endsequence

  sequence s_sleep_ok;
    out_en && sleep_mode && run_sleep;
  endsequence

  a_out_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    !out_en |=> !refclk_out_pin && !refclk_out_pin_oe)
    else $error("pin active while output disabled");

  a_sleep_stop: assert property (@(posedge pclk) disable iff (!presetn)
    out_en && sleep_mode && !run_sleep |=> !refclk_out_pin && !refclk_out_pin_oe)
    else $error("pin active in sleep without run-in-sleep");

  a_src_primary: assert property (@(posedge pclk) disable iff (!presetn)
    active && !cfg_change && src_sel && divisor == refclk_pkg::DIV_BYPASS
      |=> refclk_out_pin == $past(st_ff.prim_s2))
    else $error("bypass output not following primary oscillator");

  a_half_toggle: assert property (@(posedge pclk) disable iff (!presetn)
    s_half_done |=> refclk_out_pin != $past(refclk_out_pin))
    else $error("divided output missed its toggle");

  a_hold_between: assert property (@(posedge pclk) disable iff (!presetn)
    active && !cfg_change && divisor != refclk_pkg::DIV_BYPASS && !base_rise
      |=> refclk_out_pin == $past(refclk_out_pin))
    else $error("divided output changed without a base edge");

  a_sleep_primary: assert property (@(posedge pclk) disable iff (!presetn)
    out_en && sleep_mode && src_sel && !primary_osc_default_ok |=> !refclk_out_pin_oe)
    else $error("primary source ran in sleep without suitable oscillator");

  a_bit6_zero: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_write |=> st_ff.ctrl[refclk_pkg::BIT_RSVD] == 1'b0
      && st_ff.ctrl[5:0] == $past(pwdata[5:0]) && prdata[31:8] == '0)
    else $error("control write stored wrong value");

  // Bus side: zero wait states, mapped reads return the register
  a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable |-> pready)
    else $error("access phase saw pready low");

  a_read_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_read ##0 ctrl_hit(paddr)
      |=> prdata == {refclk_pkg::RDATA_PAD, $past(st_ff.ctrl)})
    else $error("read data differs from control register");

  a_read_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_read ##0 !ctrl_hit(paddr) |=> prdata == '0)
    else $error("unmapped read returned nonzero data");

  a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && ctrl_hit(paddr) |-> !pslverr)
    else $error("error flagged on the control register");

  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && !ctrl_hit(paddr) |=> st_ff.ctrl == $past(st_ff.ctrl))
    else $error("unmapped write altered the control register");

  a_ctrl_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_go |=> st_ff.ctrl == $past(st_ff.ctrl))
    else $error("control register changed without a write");

  a_write_masked: assert property (@(posedge pclk) disable iff (!presetn)
    s_apb_write
      |=> st_ff.ctrl == ($past(pwdata[refclk_pkg::CTRL_W-1:0]) & refclk_pkg::CTRL_WMASK))
    else $error("control write not masked as expected");

  a_read_stable: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved outside a read setup");

  // Pin side: drive, gate and divide
  a_pin_needs_oe: assert property (@(posedge pclk) disable iff (!presetn)
    refclk_out_pin |-> refclk_out_pin_oe)
    else $error("pin high while not driven");

  a_awake_on: assert property (@(posedge pclk) disable iff (!presetn)
    out_en && !sleep_mode |=> refclk_out_pin_oe)
    else $error("enabled output not driven while awake");

  a_active_oe: assert property (@(posedge pclk) disable iff (!presetn)
    active |=> refclk_out_pin_oe)
    else $error("active output not driven");

  a_disabled_cnt: assert property (@(posedge pclk) disable iff (!presetn)
    !out_en |=> st_ff.cnt == refclk_pkg::CNT_ZERO)
    else $error("divider counted while output disabled");

  a_inactive_low: assert property (@(posedge pclk) disable iff (!presetn)
    !active |=> !refclk_out_pin && !refclk_out_pin_oe && st_ff.cnt == refclk_pkg::CNT_ZERO)
    else $error("inactive output left running");

  a_sleep_run: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_ok ##0 !src_sel |=> refclk_out_pin_oe)
    else $error("run-in-sleep output stopped in sleep");

  a_src_system: assert property (@(posedge pclk) disable iff (!presetn)
    s_bypass_on ##0 !src_sel |=> refclk_out_pin == $past(st_ff.sys_s2))
    else $error("bypass output not following system clock");

  a_sync_prim: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> st_ff.prim_s2 == $past(st_ff.prim_s1))
    else $error("primary oscillator synchroniser skipped a stage");

  a_sync_sys: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |=> st_ff.sys_s2 == $past(st_ff.sys_s1))
    else $error("system clock synchroniser skipped a stage");

  a_bypass_cnt: assert property (@(posedge pclk) disable iff (!presetn)
    s_bypass_on |=> st_ff.cnt == refclk_pkg::CNT_ZERO)
    else $error("counter ran while undivided");

  a_restart_cfg: assert property (@(posedge pclk) disable iff (!presetn)
    cfg_change |=> !refclk_out_pin && st_ff.cnt == refclk_pkg::CNT_ZERO)
    else $error("config change did not restart the divider");

  a_cnt_bound: assert property (@(posedge pclk) disable iff (!presetn)
    s_divided_on |-> st_ff.cnt <= half_m1)
    else $error("divider count passed its half period");

  a_cnt_step: assert property (@(posedge pclk) disable iff (!presetn)
    s_divided_on ##0 (base_rise && st_ff.cnt != half_m1)
      |=> st_ff.cnt == $past(st_ff.cnt) + refclk_pkg::CNT_ONE)
    else $error("divider count did not advance on a base edge");

  a_toggle_rise: assert property (@(posedge pclk) disable iff (!presetn)
    s_divided_on ##0 (base_rise && st_ff.cnt == half_m1 && !refclk_out_pin)
      |=> refclk_out_pin)
    else $error("divided output missed its rising edge");

  a_sleep_prim_ok: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_ok ##0 (src_sel && primary_osc_default_ok) |=> refclk_out_pin_oe)
    else $error("primary source stopped in sleep despite suitable oscillator");

  a_sleep_prim_low: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_ok ##0 (src_sel && !primary_osc_default_ok) |=> !refclk_out_pin)
    else $error("primary source pin toggled in sleep without suitable oscillator");

endmodule : reference_clock_output_divider
